// file: hdl/ccp_pkg.sv
// Package for the capture/compare/PWM unit: register map, fields, modes and carriers
package ccp_pkg;

  // ----------------------------------------------------------------
  // Register map (word index on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_UNIT_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_CAPTURE_SOURCE = 2'h1;
  localparam logic [1:0] ADDR_VALUE_LOW = 2'h2;
  localparam logic [1:0] ADDR_VALUE_HIGH = 2'h3;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_OUTPUT_BIT = 5;
  localparam int CTRL_ALIGN_BIT = 4;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h9f;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] SOURCE_RESET = 4'h0;
  localparam logic [7:0] VALUE_RESET = 8'h00;
  localparam logic [3:0] PRESCALE_MATCH = 4'hf;
  localparam logic [1:0] PRESCALE_FOUR_MATCH = 2'h3;

  // ----------------------------------------------------------------
  // Function select codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CMP_TOGGLE_CLEAR = 4'h1;
  localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_EVERY_EDGE = 4'h3;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
  localparam logic [3:0] MODE_CMP_PULSE = 4'ha;
  localparam logic [3:0] MODE_CMP_PULSE_CLEAR = 4'hb;
  localparam logic [3:0] MODE_PWM = 4'hf;

  // Capture source codes
  localparam logic [3:0] SRC_PIN = 4'h0;
  localparam logic [3:0] SRC_CMP1 = 4'h1;
  localparam logic [3:0] SRC_CMP2 = 4'h2;
  localparam logic [3:0] SRC_OSC1 = 4'h3;
  localparam logic [3:0] SRC_PIN_CHANGE = 4'h4;
  localparam logic [3:0] SRC_LOGIC_CELL1 = 4'h5;
  localparam logic [3:0] SRC_LOGIC_CELL4 = 4'h8;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
  } ccp_reg_req_type;

  typedef struct packed {
    logic pinInput;
    logic comparatorOne;
    logic comparatorTwo;
    logic oscillatorOne;
    logic pinChange;
    logic [3:0] logicCell;
  } ccp_sources_type;

  typedef struct packed {
    logic [15:0] timerValue;
    logic [7:0] periodTimer;
    logic periodMatch;
    logic [1:0] timeBaseLow;
  } ccp_timers_type;

endpackage : ccp_pkg

// file: hdl/ccp_capture_compare_pwm.sv
// Capture/compare/PWM unit with its four registers on a plain register port
// ----------------------------------------------------------------
// Behaviour notes
// ----------------------------------------------------------------
// Capture inputs pass two flops and an edge register, so an edge acts three cycles late.
// A capture loads the value bytes at the event edge; the flag pulse starts at that same edge.
// Prescaled captures count rising edges from zero after the unit was off.
// Compare acts once on the first cycle of equality, not while equality persists.
// Pulse modes hold the output high for exactly one cycle.
// Timer clear is a one-cycle request; the timer block itself clears its count.
// PWM raises its event at each period match, when the width is buffered.
// Width changes take effect only at the next period match, which keeps PWM glitchless.
// All PWM timing comes from the timer inputs, so it scales with the system clock.
// With the unit off the output keeps its last level while the enable drops.
// The enable output follows the unit state one cycle after a control write.
// Reserved capture sources select a constant low input.
// Reserved mode codes behave as idle: no events and the output level holds, but the enable output is driven high.
// The ADC trigger copies each event only while this unit is the selected source.
// Value bytes are independent; software may write them in any order.
// In compare mode a write to a value byte can itself start a match.
// Reads of the control register return the live output level in bit 5.
// Register writes land at the strobe edge; reads answer in the next cycle only.
// Read data is zero in every cycle that does not answer a read.
// Any reset clears every register and releases the output pin.
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps

module ccp_capture_compare_pwm (
  input wire logic clk_sys, // System clock, 125 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire ccp_pkg::ccp_reg_req_type regReq, // Register port request
  output logic [7:0] rdData, // Read data, valid the cycle after a read strobe
  input wire ccp_pkg::ccp_sources_type sources, // Asynchronous capture sources
  input wire ccp_pkg::ccp_timers_type timers, // Timer values from timer blocks
  input wire logic adcTriggerSelected, // This unit is the ADC trigger source
  output logic unitOut, // Unit output level to pin
  output logic unitOutEnable, // Output enable, high while driving the pin
  output logic timerClear, // One-cycle request to clear the compare timer
  output logic interruptFlagSet, // One-cycle pulse setting the unit interrupt flag
  output logic adcTrigger // One-cycle ADC conversion trigger
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic alignLeft;
    logic [3:0] mode;
    logic [3:0] source;
    logic [7:0] valueLow;
    logic [7:0] valueHigh;
    logic [8:0] syncA;
    logic [8:0] syncB;
    logic capPrev;
    logic [3:0] prescale;
    logic [9:0] widthBuf;
    logic outLevel;
    logic pulseActive;
    logic matchPrev;
    logic [7:0] rdData;
    logic outEnable;
    logic timerClear;
    logic intSet;
    logic adcTrig;
  } ccp_state_type;

  ccp_state_type state;
  ccp_state_type next_state;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic isCapture(input logic [3:0] m);
    isCapture = (m >= ccp_pkg::MODE_CAP_EVERY_EDGE) && (m <= ccp_pkg::MODE_CAP_RISE16);
  endfunction : isCapture

  function automatic logic isCompare(input logic [3:0] m);
    isCompare = (m == ccp_pkg::MODE_CMP_TOGGLE_CLEAR) || (m == ccp_pkg::MODE_CMP_TOGGLE)
      || ((m >= ccp_pkg::MODE_CMP_SET) && (m <= ccp_pkg::MODE_CMP_PULSE_CLEAR));
  endfunction : isCompare

  function automatic logic [8:0] packSources(input ccp_pkg::ccp_sources_type s);
    packSources = {s.logicCell, s.pinChange, s.oscillatorOne, s.comparatorTwo, s.comparatorOne, s.pinInput};
  endfunction : packSources

  function automatic logic isPwm(input logic [3:0] m);
    isPwm = (m == ccp_pkg::MODE_PWM);
  endfunction : isPwm

  // Codes above the last compare mode and below PWM do nothing
  function automatic logic isReserved(input logic [3:0] m);
    isReserved = (m > ccp_pkg::MODE_CMP_PULSE_CLEAR) && (m < ccp_pkg::MODE_PWM);
  endfunction : isReserved

  // Capture trigger for the current edge, mode and rising-edge count
  function automatic logic captureTrigger(
    input logic [3:0] m,
    input logic rise,
    input logic fall,
    input logic [3:0] count
  );
    captureTrigger = 1'b0;
    case (m)
      ccp_pkg::MODE_CAP_EVERY_EDGE: begin
        captureTrigger = rise || fall;
      end
      ccp_pkg::MODE_CAP_FALL: begin
        captureTrigger = fall;
      end
      ccp_pkg::MODE_CAP_RISE: begin
        captureTrigger = rise;
      end
      ccp_pkg::MODE_CAP_RISE4: begin
        captureTrigger = rise && (count[1:0] == ccp_pkg::PRESCALE_FOUR_MATCH);
      end
      ccp_pkg::MODE_CAP_RISE16: begin
        captureTrigger = rise && (count == ccp_pkg::PRESCALE_MATCH);
      end
      default: begin
        captureTrigger = 1'b0;
      end
    endcase
  endfunction : captureTrigger

  // One-hot register select, shared by the write and read paths
  function automatic logic [3:0] regSelect(input logic [1:0] a);
    regSelect = 4'h0;
    if (a == ccp_pkg::ADDR_UNIT_CONTROL) begin
      regSelect = 4'h1;
    end else if (a == ccp_pkg::ADDR_CAPTURE_SOURCE) begin
      regSelect = 4'h2;
    end else if (a == ccp_pkg::ADDR_VALUE_LOW) begin
      regSelect = 4'h4;
    end else begin
      regSelect = 4'h8;
    end
  endfunction : regSelect

  // ----------------------------------------------------------------
  // Combinational helpers
  // ----------------------------------------------------------------

  logic [8:0] rawSources;
  logic capIn;
  logic riseEdge;
  logic fallEdge;
  logic capEvent;
  logic cmpMatch;
  logic [9:0] widthNow;
  logic [9:0] timeBase;
  logic active;
  logic [3:0] regSel;

  assign rawSources = packSources(sources);

  // ----------------------------------------------------------------
  // Combinational next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.timerClear = 1'b0;
    next_state.intSet = 1'b0;
    next_state.adcTrig = 1'b0;
    next_state.rdData = 8'h00;
    regSel = regSelect(regReq.addr);

    // ----------------------------------------------------------------
    // Synchroniser and capture source
    // ----------------------------------------------------------------
    // Two-stage synchroniser for all asynchronous sources
    next_state.syncA = rawSources;
    next_state.syncB = state.syncA;
    active = state.enable && (state.mode != ccp_pkg::MODE_OFF);
    capIn = 1'b0;
    if (state.source == ccp_pkg::SRC_PIN) begin
      capIn = state.syncB[0];
    end else if (state.source <= ccp_pkg::SRC_LOGIC_CELL4) begin
      capIn = state.syncB[state.source];
    end
    riseEdge = capIn && !state.capPrev;
    fallEdge = !capIn && state.capPrev;
    next_state.capPrev = capIn;

    // ----------------------------------------------------------------
    // Compare and PWM datapath
    // ----------------------------------------------------------------
    // full 16-bit equality
    cmpMatch = ({state.valueHigh, state.valueLow} == timers.timerValue);
    if (state.alignLeft) begin
      widthNow = {state.valueHigh, state.valueLow[7:6]};
    end else begin
      widthNow = {state.valueHigh[1:0], state.valueLow};
    end
    timeBase = {timers.periodTimer, timers.timeBaseLow};
    capEvent = 1'b0;
    next_state.matchPrev = cmpMatch;

    // ----------------------------------------------------------------
    // Mode actions
    // ----------------------------------------------------------------
    if (!active) begin
      // off mode holds internal state reset
      next_state.prescale = 4'h0;
      next_state.pulseActive = 1'b0;
      next_state.matchPrev = 1'b0;
    end else if (isCapture(state.mode)) begin
      capEvent = captureTrigger(state.mode, riseEdge, fallEdge, state.prescale);
      if (riseEdge) begin
        next_state.prescale = state.prescale + 4'h1;
      end
      if (capEvent) begin
        next_state.valueLow = timers.timerValue[7:0];
        next_state.valueHigh = timers.timerValue[15:8];
      end
    end else if (isCompare(state.mode)) begin
      next_state.pulseActive = 1'b0;
      if (state.pulseActive) begin
        next_state.outLevel = 1'b0;
      end
      if (cmpMatch && !state.matchPrev) begin
        capEvent = 1'b1;
        case (state.mode)
          ccp_pkg::MODE_CMP_TOGGLE_CLEAR: begin
            next_state.outLevel = !state.outLevel;
            next_state.timerClear = 1'b1;
          end
          ccp_pkg::MODE_CMP_TOGGLE: begin
            next_state.outLevel = !state.outLevel;
          end
          ccp_pkg::MODE_CMP_SET: begin
            next_state.outLevel = 1'b1;
          end
          ccp_pkg::MODE_CMP_CLEAR: begin
            next_state.outLevel = 1'b0;
          end
          ccp_pkg::MODE_CMP_PULSE_CLEAR: begin
            next_state.outLevel = 1'b1;
            next_state.pulseActive = 1'b1;
            next_state.timerClear = 1'b1;
          end
          default: begin
            next_state.outLevel = 1'b1;
            next_state.pulseActive = 1'b1;
          end
        endcase
      end
    end else if (isReserved(state.mode)) begin
      next_state.prescale = 4'h0;
      next_state.pulseActive = 1'b0;
      next_state.matchPrev = 1'b0;
    end else if (isPwm(state.mode)) begin
      // PWM only on its own code; reserved codes stay idle
      // period match restarts the cycle and buffers the width
      // all PWM timing taken from clk_sys and the timer inputs
      if (timers.periodMatch) begin
        next_state.widthBuf = widthNow;
        next_state.outLevel = (widthNow != 10'h000);
        capEvent = 1'b1;
      end else if (timeBase == state.widthBuf) begin
        next_state.outLevel = 1'b0;
      end
    end

    // ----------------------------------------------------------------
    // Event outputs
    // ----------------------------------------------------------------
    // interrupt flag on each event; ADC trigger only while adcTriggerSelected
    if (capEvent) begin
      next_state.intSet = 1'b1;
      next_state.adcTrig = adcTriggerSelected;
    end
    next_state.outEnable = active;

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    if (regReq.wrStrobe) begin
      if (regSel[0]) begin
        next_state.enable = regReq.wrData[ccp_pkg::CTRL_ENABLE_BIT];
        next_state.alignLeft = regReq.wrData[ccp_pkg::CTRL_ALIGN_BIT];
        next_state.mode = regReq.wrData[3:0];
      end else if (regSel[1]) begin
        next_state.source = regReq.wrData[3:0];
      end else if (regSel[2]) begin
        next_state.valueLow = regReq.wrData;
      end else begin
        next_state.valueHigh = regReq.wrData;
      end
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    if (regReq.rdStrobe) begin
      if (regSel[0]) begin
        // read-only output level; bit 6 reads zero
        next_state.rdData = {state.enable, 1'b0, state.outLevel, state.alignLeft, state.mode}
          & (ccp_pkg::CTRL_WRITE_MASK | (8'h01 << ccp_pkg::CTRL_OUTPUT_BIT));
      end else if (regSel[1]) begin
        next_state.rdData = {4'h0, state.source};
      end else if (regSel[2]) begin
        next_state.rdData = state.valueLow;
      end else begin
        next_state.rdData = state.valueHigh;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // every register to its reset value, pin released
      state <= '0;
      state.mode <= ccp_pkg::CTRL_RESET[3:0];
      state.source <= ccp_pkg::SOURCE_RESET;
      state.valueLow <= ccp_pkg::VALUE_RESET;
      state.valueHigh <= ccp_pkg::VALUE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // timers arrive on ports; outputs straight from flops
  assign rdData = state.rdData;
  assign unitOut = state.outLevel;
  assign unitOutEnable = state.outEnable;
  assign timerClear = state.timerClear;
  assign interruptFlagSet = state.intSet;
  assign adcTrigger = state.adcTrig;

endmodule : ccp_capture_compare_pwm

// file: verif/ccp_timer_model.sv
// Timer and period time-base model feeding the unit
`timescale 1ns/1ps
module ccp_timer_model (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic setEn, // Load timer value
  input wire logic [15:0] setVal, // Value to load
  input wire logic [7:0] periodValue, // Period value
  input wire logic timerClear, // Clear request from the unit
  output ccp_pkg::ccp_timers_type timers // Timer carrier
);
  logic [15:0] tv;
  logic [7:0] pt;
  logic [1:0] tbl;
  assign timers = '{tv, pt, (pt == periodValue) && (tbl == 2'h3), tbl};
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tv <= 16'h0000;
      pt <= 8'h00;
      tbl <= 2'h0;
    end else begin
      tbl <= tbl + 2'h1;
      if (tbl == 2'h3) begin
        pt <= (pt == periodValue) ? 8'h00 : pt + 8'h01;
      end
      if (timerClear) begin
        tv <= 16'h0000;
      end else if (setEn) begin
        tv <= setVal;
      end
    end
  end
endmodule : ccp_timer_model

// file: verif/ccp_capture_compare_pwm_properties.sv
// Port checks for the capture/compare/PWM unit
`timescale 1ns/1ps
module ccp_capture_compare_pwm_properties (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset
  input wire ccp_pkg::ccp_reg_req_type regReq, // Register request
  input wire logic [7:0] rdData, // Read data
  input wire logic adcTrigger, // ADC trigger
  input wire logic unitOut, // Output level
  input wire logic unitOutEnable, // Output enable
  input wire logic interruptFlagSet // Interrupt pulse
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  property p_reset;
    disable iff (1'b0) rst |=> !unitOutEnable && rdData == 8'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_idle;
    !regReq.rdStrobe |=> rdData == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside read cycle");
  property p_bit6;
    regReq.rdStrobe && regReq.addr == 2'h0 |=> !rdData[6];
  endproperty
  a_bit6: assert property (p_bit6) else $error("control bit 6 not zero");
  property p_srchi;
    regReq.rdStrobe && regReq.addr == 2'h1 |=> rdData[7:4] == 4'h0;
  endproperty
  a_srchi: assert property (p_srchi) else $error("source high bits not zero");
  property p_out;
    regReq.rdStrobe && regReq.addr == 2'h0 |=> rdData[5] == $past(unitOut);
  endproperty
  a_out: assert property (p_out) else $error("output bit differs from output");
  property p_adc;
    adcTrigger |-> interruptFlagSet;
  endproperty
  a_adc: assert property (p_adc) else $error("ADC trigger without event");
  property p_off;
    interruptFlagSet |-> unitOutEnable || $past(unitOutEnable);
  endproperty
  a_off: assert property (p_off) else $error("event while unit off");
  property p_hold;
    !unitOutEnable && $past(!unitOutEnable) |-> $stable(unitOut);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved while off");
endmodule : ccp_capture_compare_pwm_properties
bind ccp_capture_compare_pwm ccp_capture_compare_pwm_properties ccp_capture_compare_pwm_properties_i (
  .clk_sys(clk_sys), .rst(rst), .regReq(regReq), .rdData(rdData), .adcTrigger(adcTrigger),
  .unitOut(unitOut), .unitOutEnable(unitOutEnable), .interruptFlagSet(interruptFlagSet));

// file: verif/ccp_capture_compare_pwm_tb.sv
// Self-checking bench for the capture/compare/PWM unit
`timescale 1ns/1ps
module ccp_capture_compare_pwm_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  ccp_pkg::ccp_reg_req_type regReq = '0;
  ccp_pkg::ccp_sources_type sources = '0;
  ccp_pkg::ccp_timers_type timers;
  logic adcTriggerSelected = 1'b1;
  logic setEn = 1'b0;
  logic [15:0] setVal = 16'h0000;
  logic [7:0] rdData;
  logic unitOut, unitOutEnable, timerClear, interruptFlagSet, adcTrigger;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  int nHigh, nClr, nIrq, nAdc, b;
  always #4 clk_sys = ~clk_sys;
  ccp_capture_compare_pwm ccp_capture_compare_pwm_i (.clk_sys(clk_sys), .rst(rst), .regReq(regReq),
    .rdData(rdData), .sources(sources), .timers(timers), .adcTriggerSelected(adcTriggerSelected),
    .unitOut(unitOut), .unitOutEnable(unitOutEnable), .timerClear(timerClear),
    .interruptFlagSet(interruptFlagSet), .adcTrigger(adcTrigger));
  ccp_timer_model ccp_timer_model_i (.clk_sys(clk_sys), .rst(rst), .setEn(setEn), .setVal(setVal),
    .periodValue(8'h03), .timerClear(timerClear), .timers(timers));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  always @(negedge clk_sys) begin
    cycles++;
    nHigh += unitOut;
    nClr += timerClear;
    nIrq += interruptFlagSet;
    nAdc += adcTrigger;
    if (cycles > 20000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    regReq <= '0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    regReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    regReq <= '0;
    #1 cmp(rdData, e, "read");
  endtask : rd
  task automatic tmr(input logic [15:0] v);
    @(posedge clk_sys);
    setEn <= 1'b1;
    setVal <= v;
    @(posedge clk_sys);
    setEn <= 1'b0;
  endtask : tmr
  task automatic zero();
    @(posedge clk_sys);
    {nHigh, nClr, nIrq, nAdc} = '0;
  endtask : zero
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  logic [3:0] cm [6] = '{4'h8, 4'h9, 4'h2, 4'h1, 4'ha, 4'hb};
  logic [5:0] cOut = 6'b000101;
  logic [5:0] cClr = 6'b101000;
  logic [3:0] capMode [8] = '{4'h5, 4'h4, 4'h3, 4'h6, 4'h7, 4'h5, 4'h5, 4'h5};
  logic [3:0] capSrc [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h4, 4'h8, 4'h9};
  int capTog [8] = '{4, 4, 4, 8, 32, 4, 4, 4};
  int capExp [8] = '{2, 2, 4, 1, 1, 2, 2, 0};
  logic [7:0] pw [3][3] = '{'{8'h8f, 8'h06, 8'hfc}, '{8'h9f, 8'hbf, 8'h02}, '{8'h8f, 8'h00, 8'h00}};
  int pwW [3] = '{6, 10, 0};
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 0; a < 4; a++) rd(a[1:0], 8'h00);
    wr(2'h0, 8'hff);
    rd(2'h0, 8'h9f);
    wr(2'h1, 8'hff);
    rd(2'h1, 8'h0f);
    wr(2'h2, 8'h34);
    wr(2'h3, 8'h12);
    rd(2'h2, 8'h34);
    rd(2'h3, 8'h12);
    $display("registers done");
    for (int i = 0; i < 6; i++) begin
      adcTriggerSelected <= (i != 1);
      wr(2'h0, {4'h8, cm[i]});
      tmr(16'h0000);
      zero();
      tmr(16'h1334);
      repeat (3) @(posedge clk_sys);
      tmr(16'h1234);
      repeat (6) @(posedge clk_sys);
      cmp(unitOut, cOut[i], "compare out");
      cmp(nClr, cClr[i], "timer clear");
      cmp(nIrq, 1, "compare event");
      cmp(nAdc, i != 1, "adc trigger");
      if (i > 3) cmp(nHigh, 1, "pulse length");
      if (i == 0) rd(2'h0, 8'ha8);
    end
    $display("compare done");
    for (int i = 0; i < 8; i++) begin
      wr(2'h0, 8'h00);
      @(posedge clk_sys);
      #1 cmp(unitOutEnable, 1'b0, "off enable");
      tmr(16'ha000 | i[15:0]);
      wr(2'h2, 8'h00);
      wr(2'h3, 8'h00);
      wr(2'h1, {4'h0, capSrc[i]});
      wr(2'h0, {4'h8, capMode[i]});
      @(posedge clk_sys);
      #1 cmp(unitOutEnable, 1'b1, "on enable");
      zero();
      b = (capSrc[i] < 5) ? 8 - capSrc[i] : (capSrc[i] - 5) % 4;
      repeat (capTog[i]) begin
        @(posedge clk_sys);
        sources[b] <= ~sources[b];
        repeat (4) @(posedge clk_sys);
      end
      repeat (6) @(posedge clk_sys);
      cmp(nIrq, capExp[i], "capture events");
      rd(2'h2, capExp[i] ? i : 0);
      rd(2'h3, capExp[i] ? 8'ha0 : 8'h00);
    end
    $display("capture done");
    for (int i = 0; i < 3; i++) begin
      wr(2'h2, pw[i][1]);
      wr(2'h3, pw[i][2]);
      wr(2'h0, pw[i][0]);
      repeat (40) @(posedge clk_sys);
      @(posedge clk_sys iff timers.periodMatch);
      {nHigh, nClr, nIrq, nAdc} = '0;
      repeat (16) @(posedge clk_sys);
      cmp(nHigh, pwW[i] ? pwW[i] + 1 : 0, "pwm high time");
      cmp(nIrq, 1, "pwm event");
    end
    $display("pwm done");
    wr(2'h0, 8'h8d);
    zero();
    repeat (20) @(posedge clk_sys);
    cmp(nIrq + nHigh + nClr, 0, "reserved idle");
    $display("reserved done");
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1 cmp(unitOutEnable, 1'b0, "reset enable");
    rd(2'h0, 8'h00);
    $display("reset done");
    end_sim();
  end
endmodule : ccp_capture_compare_pwm_tb
